// ===== bench/rsw_host_model.sv
// Host microcontroller stand-in that pulses the kick pin
`timescale 1ns/1ns
module rsw_host_model #(
  parameter int HALF = 10
) (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic run_in,
  output logic      kick_out
);
  int   cnt = 0;
  logic lvl = 1'b1;
  assign kick_out = lvl;
  // Firmware runs only out of reset; a fall every 2*HALF cycles
  always @(posedge mclk_in)
    if (run_in && rst_n_in)
    begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
        lvl <= !lvl;
    end
endmodule : rsw_host_model

// ===== bench/rsw_top_properties.sv
// Port checker for the regulator supervisor, bound into the top
`timescale 1ns/1ns
module rsw_top_properties #(
  parameter int unsigned POR_CYC       = 20,
  parameter int unsigned BOOT_CYC      = 40,
  parameter int unsigned KICK_CYC      = 60,
  parameter int unsigned BOOT_OPEN_CYC = 50,
  parameter int unsigned KICK_OPEN_CYC = 70
) (
  input wire logic                 mclk_in,
  input wire logic                 rst_b_in,
  input wire rsw_pkg::rsw_wb_req_t wb_req_in,
  input wire rsw_pkg::rsw_wb_rsp_t wb_rsp_out,
  input wire logic                 kick_in,
  input wire logic                 supply_under_in,
  input wire logic                 supply_over_in,
  input wire logic                 overtemp_in,
  input wire logic                 fb_below_low_in,
  input wire logic                 five_volt_ldo_ok_in,
  input wire logic                 gate_drive_ldo_ok_in,
  input wire logic                 five_volt_ldo_low_in,
  input wire logic                 system_reset_out_n,
  input wire logic                 ldo_power_good_out,
  input wire logic                 five_volt_ldo_en_out,
  input wire logic                 gate_drive_ldo_en_out,
  input wire logic                 smps_switch_en_out,
  input wire logic                 soft_start_run_out
);
  logic [15:0] lo_r;
  logic [15:0] hi_r;
  logic        kick_r;
  logic [1:0]  dly_r;
  logic [31:0] kick_lim;
  // Delay setting mirrored from taken bus writes, so the kick bound follows it
  always_ff @(posedge mclk_in)
    if (!rst_b_in)
      dly_r <= 2'h0;
    else if (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack && wb_req_in.we &&
             wb_req_in.sel[0] && wb_req_in.adr == 8'h00)
      dly_r <= wb_req_in.dat[1:0];
  // Slower settings scale boot and kick windows; open uses the ceilings
  assign kick_lim = (dly_r == 2'h3) ? 32'(BOOT_OPEN_CYC + KICK_OPEN_CYC + 8) :
                    32'(({30'h0, dly_r} + 32'h1) * (BOOT_CYC + KICK_CYC) + 32'h8);
  // Cycles with reset held low, saturating
  always_ff @(posedge mclk_in)
    if (!rst_b_in || system_reset_out_n)
      lo_r <= 16'h0000;
    else if (lo_r != 16'hFFFF)
      lo_r <= lo_r + 16'h0001;
  // Previous kick level for edge finding
  always_ff @(posedge mclk_in)
    kick_r <= kick_in;
  // Reset-high cycles since release or last kick fall
  always_ff @(posedge mclk_in)
    if (!rst_b_in || !system_reset_out_n || (kick_r && !kick_in))
      hi_r <= 16'h0000;
    else if (hi_r != 16'hFFFF)
      hi_r <= hi_r + 16'h0001;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_taken;
    wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
  endsequence
  // Filter takes four edges, so eight held cycles leave margin
  sequence s_all_off;
    !five_volt_ldo_en_out && !gate_drive_ldo_en_out && !smps_switch_en_out
      && !system_reset_out_n;
  endsequence
  a_ack_reply: assert property (s_taken |=> wb_rsp_out.ack)
    else $error("bus request not answered in one cycle");
  a_ack_pulse: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
    else $error("bus ack longer than one cycle");
  a_uv_all_off: assert property (supply_under_in [*8] |-> s_all_off)
    else $error("outputs on during supply undervoltage");
  a_ov_all_off: assert property (supply_over_in [*8] |-> s_all_off)
    else $error("outputs on during supply overvoltage");
  a_hot_all_off: assert property (overtemp_in [*8] |-> s_all_off)
    else $error("outputs on during over-temperature");
  a_pg_low: assert property (five_volt_ldo_low_in [*8] |-> !ldo_power_good_out)
    else $error("power good high with five-volt output low");
  a_fb_low_rst: assert property (fb_below_low_in [*8] |-> !system_reset_out_n)
    else $error("reset high with feedback low");
  a_ss_needs_ldo: assert property ($rose(soft_start_run_out)
    |-> five_volt_ldo_ok_in || gate_drive_ldo_ok_in)
    else $error("soft-start began with no LDO up");
  a_ldo_first: assert property ($rose(smps_switch_en_out)
    |-> five_volt_ldo_en_out && gate_drive_ldo_en_out)
    else $error("switcher started before LDOs");
  a_por_hold: assert property ($rose(system_reset_out_n) |-> lo_r >= POR_CYC)
    else $error("reset released before hold delay");
  a_kick_bound: assert property (system_reset_out_n
    |-> hi_r <= kick_lim)
    else $error("reset stayed high with no kicks");
endmodule : rsw_top_properties

bind rsw_top rsw_top_properties #(
  .POR_CYC      (POR_CYC),
  .BOOT_CYC     (BOOT_CYC),
  .KICK_CYC     (KICK_CYC),
  .BOOT_OPEN_CYC(BOOT_OPEN_CYC),
  .KICK_OPEN_CYC(KICK_OPEN_CYC)
) i_rsw_top_properties (.*);

// ===== bench/rsw_top_test.sv
// Self-checking bench for the regulator supervisor
`timescale 1ns/1ns
module rsw_top_test;
  localparam int P = 20;
  localparam int B = 40;
  localparam int K = 60;
  logic                 mclk_in = 1'b0;
  logic                 rst_b_in = 1'b0;
  rsw_pkg::rsw_wb_req_t wb_req_in = '0;
  rsw_pkg::rsw_wb_rsp_t wb_rsp_out;
  logic enable_in = 1'b0, supply_start_ok_in = 1'b0, fb_short_in = 1'b0;
  logic five_volt_ldo_low_in = 1'b0, run = 1'b0;
  logic fb_above_high_in = 1'b0, fb_below_low_in = 1'b1;
  logic five_volt_ldo_ok_in = 1'b0, gate_drive_ldo_ok_in = 1'b0;
  logic [2:0] flt = 3'h0;
  wire supply_under_in, overtemp_in, supply_over_in, kick_in;
  logic system_reset_out_n, ignition_mirror_out, ldo_power_good_out;
  logic five_volt_ldo_en_out, gate_drive_ldo_en_out;
  logic smps_switch_en_out, soft_start_run_out;
  logic [31:0] q;
  int n_mismatch = 0;
  int total_checks = 0;
  wire [3:0] outs = {five_volt_ldo_en_out, gate_drive_ldo_en_out,
                     smps_switch_en_out, system_reset_out_n};
  assign {supply_under_in, overtemp_in, supply_over_in} = flt;

  rsw_top #(
    .POR_CYC      (P),
    .BOOT_CYC     (B),
    .KICK_CYC     (K),
    .SS_CYC       (10),
    .POR_OPEN_CYC (30),
    .BOOT_OPEN_CYC(50),
    .KICK_OPEN_CYC(70)
  ) i_rsw_top (.*);

  rsw_host_model #(
    .HALF(10)
  ) i_rsw_host_model (
    .mclk_in (mclk_in),
    .rst_n_in(system_reset_out_n),
    .run_in  (run),
    .kick_out(kick_in)
  );

  initial
    forever #20 mclk_in = !mclk_in;

  // Analog stand-in: LDO levels and feedback follow the enables
  always @(posedge mclk_in)
  begin
    five_volt_ldo_ok_in <= five_volt_ldo_en_out;
    gate_drive_ldo_ok_in <= gate_drive_ldo_en_out;
    fb_above_high_in <= smps_switch_en_out && !fb_short_in;
    fb_below_low_in <= !smps_switch_en_out || fb_short_in;
  end

  task tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick

  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Classic single cycle; held until ack is sampled high
  task wb_io(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk_in);
    wb_req_in <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (wb_rsp_out.ack !== 1'b1 && n < 20);
    chk(32'(wb_rsp_out.ack), 32'h1);
    r = wb_rsp_out.dat;
    wb_req_in <= '0;
  endtask : wb_io

  // Bounded wait for a reset level, then compare it
  task wait_rst(input logic v, input int n);
    for (int i = 0; i < n && system_reset_out_n !== v; i++)
      @(posedge mclk_in);
    chk(32'(system_reset_out_n), 32'(v));
  endtask : wait_rst

  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial
  begin
    tick(16);
    rst_b_in <= 1'b1;
    wb_io(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h0);
    wb_io(1'b1, 8'h00, 32'hFFFFFFFF, q);
    wb_io(1'b0, 8'h00, 32'h0, q);
    chk(q, 32'h3);
    wb_io(1'b1, 8'h08, 32'hFFFFFFFF, q);
    wb_io(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h0);
    wb_io(1'b1, 8'h00, 32'h0, q);
    $display("test bus done");
    supply_start_ok_in <= 1'b1;
    tick(12);
    chk(32'(outs), 32'h0);
    wb_io(1'b0, 8'h04, 32'h0, q);
    chk(32'(q[7:1]), 32'(rsw_pkg::ST_STANDBY));
    enable_in <= 1'b1;
    run <= 1'b1;
    tick(30);
    chk(32'({outs, ignition_mirror_out}), 32'h1D);
    wait_rst(1'b1, 60);
    tick(B + 2 * K);
    chk(32'(outs), 32'hF);
    $display("test start done");
    // Kicks stop with enable high: reset pulses, outputs stay
    @(negedge kick_in);
    run <= 1'b0;
    tick(K - 8);
    chk(32'(system_reset_out_n), 32'h1);
    wait_rst(1'b0, 20);
    chk(32'(outs), 32'hE);
    tick(P / 2);
    chk(32'(system_reset_out_n), 32'h0);
    run <= 1'b1;
    wait_rst(1'b1, P + 8);
    $display("test kick done");
    // Enable low is ignored until kicks stop
    tick(40);
    enable_in <= 1'b0;
    tick(30);
    chk(32'({outs, ignition_mirror_out}), 32'h1E);
    @(negedge kick_in);
    run <= 1'b0;
    tick(K + 30);
    chk(32'(outs), 32'h0);
    wb_io(1'b0, 8'h04, 32'h0, q);
    chk(32'(q[9]), 32'h0);
    $display("test standby done");
    enable_in <= 1'b1;
    run <= 1'b1;
    wait_rst(1'b1, 80);
    // Over-supply and heat restart even with enable low
    for (int i = 0; i < 3; i++)
    begin
      flt[i] <= 1'b1;
      tick(12);
      chk(32'(outs), 32'h0);
      enable_in <= (i == 2);
      wb_io(1'b0, 8'h04, 32'h0, q);
      chk(32'(q[9]), 32'(i != 2));
      flt[i] <= 1'b0;
      tick(30);
      chk(32'(outs[3:2]), 32'h3);
      enable_in <= 1'b1;
      wait_rst(1'b1, 100);
    end
    $display("test faults done");
    five_volt_ldo_low_in <= 1'b1;
    tick(10);
    chk(32'({outs, ldo_power_good_out}), 32'h1E);
    five_volt_ldo_low_in <= 1'b0;
    tick(10);
    chk(32'(ldo_power_good_out), 32'h1);
    fb_short_in <= 1'b1;
    tick(20);
    chk(32'(outs), 32'hC);
    $display("test short done");
    // Short restart by enable toggle, then a kick timeout doubled at 20k
    fb_short_in <= 1'b0;
    enable_in <= 1'b0;
    tick(10);
    wb_io(1'b1, 8'h00, 32'h1, q);
    enable_in <= 1'b1;
    wait_rst(1'b1, 200);
    tick(2 * B + 10);
    @(negedge kick_in);
    run <= 1'b0;
    tick(2 * K - 8);
    chk(32'(system_reset_out_n), 32'h1);
    wait_rst(1'b0, 20);
    $display("test delay done");
    print_verdict();
  end

  // Hang guard, well past the expected run length
  initial
  begin
    tick(6000);
    n_mismatch++;
    print_verdict();
  end
endmodule : rsw_top_test

// ===== logic/rsw_cfg.svh
// Constants for the regulator supervisor and watchdog block
// Function
// - Pull reset low when no kick falling edge comes within the kick timeout.
// - Hold reset low for the power-on hold delay after feedback turns good.
// - Give a boot window after reset release before kick monitoring starts.
// - With delay resistor open, bound delays to 110, 1100 and 1300 ms.
// - Before a valid enable, hold reset low once supply is above start.
// - Supply undervoltage: reset low, all off, latch cleared; recover needs enable.
// - Supply overvoltage: all off, latch kept; restart on removal regardless of enable.
// - Over-temperature: all off, latch kept; resume when cool regardless of enable.
// - Supply valid and enable low: standby, everything off, reset low.
// - Enable high brings up both LDOs first, then switching soft-start.
// - After an LDO regulates, ignore enable low until soft-start timer expiry.
// - After timer expiry, enable low gives standby only on output loss, output short or timeout.
// - While latched, ignition mirror follows enable level.
// - Enable falling while unlatched stops enable driving the ignition mirror.
// - Start soft-start only once either LDO is above its start level.
// - Pull LDO power-good low while five-volt LDO is below its stop level.
// - LDO out of regulation only current-limits it; nothing else changes.
// - Output loss with enable low shuts all; with enable high holds reset low.
// - Output short: enable high latches switcher off; enable low shuts all.
// - Kick timeout: enable high pulses reset; enable low shuts everything.
// - Kick in time restarts timeout; else re-enter power-on hold with reset low.
// - Feedback below low level holds reset low and reinitialises all delays.
// - Removal of over-supply, heat or output loss reruns power-on and boot delays.
`ifndef RSW_CFG_SVH
`define RSW_CFG_SVH
`define RSW_CLK_HZ          25000000
`define RSW_POR_US          5000
`define RSW_BOOT_US         50000
`define RSW_KICK_US         60000
`define RSW_SS_US           5000
`define RSW_POR_OPEN_US     110000
`define RSW_BOOT_OPEN_US    1100000
`define RSW_KICK_OPEN_US    1300000
`define RSW_US2CYC(us)      (((us) * (`RSW_CLK_HZ / 1000)) / 1000)
`define RSW_ADR_CTRL        8'h00
`define RSW_ADR_STATUS      8'h04
`define RSW_CTRL_RST        2'h0
`define RSW_IN_ENABLE       0
`define RSW_IN_KICK         1
`define RSW_IN_SUP_START    2
`define RSW_IN_SUP_UV       3
`define RSW_IN_SUP_OV       4
`define RSW_IN_OVERTEMP     5
`define RSW_IN_FB_HIGH      6
`define RSW_IN_FB_LOW       7
`define RSW_IN_FB_SHORT     8
`define RSW_IN_FIVE_OK      9
`define RSW_IN_GATE_OK      10
`define RSW_IN_FIVE_LOW     11
`define RSW_IN_COUNT        12
`endif

// ===== logic/rsw_pkg.sv
// Types shared by the regulator supervisor block
package rsw_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } rsw_wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rsw_wb_rsp_t;
  typedef enum logic [6:0] {
    ST_OFF      = 7'h01,
    ST_STANDBY  = 7'h02,
    ST_LDO_UP   = 7'h04,
    ST_SOFT     = 7'h08,
    ST_RUN      = 7'h10,
    ST_SHUT     = 7'h20,
    ST_LATCHOFF = 7'h40
  } rsw_main_t;
  typedef enum logic [3:0] {
    WD_IDLE = 4'h1,
    WD_POR  = 4'h2,
    WD_BOOT = 4'h4,
    WD_MON  = 4'h8
  } rsw_wd_t;
  typedef enum logic [1:0] {
    DLY_10K  = 2'h0,
    DLY_20K  = 2'h1,
    DLY_30K  = 2'h2,
    DLY_OPEN = 2'h3
  } rsw_dly_t;
endpackage : rsw_pkg

// ===== logic/rsw_top.sv
// Regulator supervisor: power sequencing, fault responses and kick watchdog
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`include "rsw_cfg.svh"
module rsw_top #(
  parameter int unsigned POR_CYC       = `RSW_US2CYC(`RSW_POR_US),
  parameter int unsigned BOOT_CYC      = `RSW_US2CYC(`RSW_BOOT_US),
  parameter int unsigned KICK_CYC      = `RSW_US2CYC(`RSW_KICK_US),
  parameter int unsigned SS_CYC        = `RSW_US2CYC(`RSW_SS_US),
  parameter int unsigned POR_OPEN_CYC  = `RSW_US2CYC(`RSW_POR_OPEN_US),
  parameter int unsigned BOOT_OPEN_CYC = `RSW_US2CYC(`RSW_BOOT_OPEN_US),
  parameter int unsigned KICK_OPEN_CYC = `RSW_US2CYC(`RSW_KICK_OPEN_US)
) (
  input  wire logic                 mclk_in,
  input  wire logic                 rst_b_in,
  input  wire rsw_pkg::rsw_wb_req_t wb_req_in,
  output rsw_pkg::rsw_wb_rsp_t      wb_rsp_out,
  input  wire logic                 enable_in,
  input  wire logic                 kick_in,
  input  wire logic                 supply_start_ok_in,
  input  wire logic                 supply_under_in,
  input  wire logic                 supply_over_in,
  input  wire logic                 overtemp_in,
  input  wire logic                 fb_above_high_in,
  input  wire logic                 fb_below_low_in,
  input  wire logic                 fb_short_in,
  input  wire logic                 five_volt_ldo_ok_in,
  input  wire logic                 gate_drive_ldo_ok_in,
  input  wire logic                 five_volt_ldo_low_in,
  output logic                      system_reset_out_n,
  output logic                      ignition_mirror_out,
  output logic                      ldo_power_good_out,
  output logic                      five_volt_ldo_en_out,
  output logic                      gate_drive_ldo_en_out,
  output logic                      smps_switch_en_out,
  output logic                      soft_start_run_out
);

  // Refuse counts the 32-bit timers cannot hold or that round to nothing
  if (POR_CYC < 1 || BOOT_CYC < 1 || KICK_CYC < 1 || SS_CYC < 1 ||
      POR_CYC > 32'h3FFFFFFF || BOOT_CYC > 32'h3FFFFFFF || KICK_CYC > 32'h3FFFFFFF ||
      POR_OPEN_CYC < 1 || BOOT_OPEN_CYC < 1 || KICK_OPEN_CYC < 1)
  begin : g_bad_counts
    $error("rsw_top: delay counts out of range");
  end

  localparam int unsigned NIN = `RSW_IN_COUNT;

  logic [NIN-1:0]    raw_in;
  logic [NIN-1:0]    sy1_r;
  logic [NIN-1:0]    sy2_r;
  logic [NIN-1:0]    sy3_r;
  logic [NIN-1:0]    pin_r;
  logic              kick_prev_r;
  logic              kick_fall;
  logic              en_s;
  logic              sup_fail;
  logic              hot_or_over;
  logic              ldo_ok;
  rsw_pkg::rsw_dly_t dly_sel_r;
  rsw_pkg::rsw_main_t st_r;
  rsw_pkg::rsw_wd_t  wd_r;
  logic              latch_r;
  logic              ss_done_r;
  logic [31:0]       ss_cnt_r;
  logic [31:0]       wd_cnt_r;
  logic [31:0]       por_term;
  logic [31:0]       boot_term;
  logic [31:0]       kick_term;
  logic              wd_timeout;
  logic              reg_ok;
  logic              short_en_seen_low_r;
  logic              ign_r;
  logic              ack_r;
  logic [31:0]       rdat_r;
  logic              wb_hit;

  assign raw_in = {five_volt_ldo_low_in, gate_drive_ldo_ok_in, five_volt_ldo_ok_in,
                   fb_short_in, fb_below_low_in, fb_above_high_in, overtemp_in,
                   supply_over_in, supply_under_in, supply_start_ok_in, kick_in,
                   enable_in};

  // Pin comparators are asynchronous: three stages, accept once stages two and three agree
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      sy1_r <= '0;
      sy2_r <= '0;
      sy3_r <= '0;
      pin_r <= '0;
    end
    else
    begin
      sy1_r <= raw_in;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      pin_r <= (sy3_r & ~(sy2_r ^ sy3_r)) | (pin_r & (sy2_r ^ sy3_r));
    end
  end

  // Kick edge taken from the filtered sample, never from a first stage
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
      kick_prev_r <= 1'b0;
    else
      kick_prev_r <= pin_r[`RSW_IN_KICK];
  end
  assign kick_fall   = kick_prev_r & ~pin_r[`RSW_IN_KICK];
  assign en_s        = pin_r[`RSW_IN_ENABLE];
  assign sup_fail    = pin_r[`RSW_IN_SUP_UV] | ~pin_r[`RSW_IN_SUP_START];
  assign hot_or_over = pin_r[`RSW_IN_SUP_OV] | pin_r[`RSW_IN_OVERTEMP];
  assign ldo_ok      = pin_r[`RSW_IN_FIVE_OK] | pin_r[`RSW_IN_GATE_OK];
  assign reg_ok      = ~pin_r[`RSW_IN_FB_LOW];

  // Terminal counts follow the delay resistor setting; open uses the bounded ceiling
  always_comb
  begin
    case (dly_sel_r)
      rsw_pkg::DLY_10K:
      begin
        por_term  = POR_CYC;
        boot_term = BOOT_CYC;
        kick_term = KICK_CYC;
      end
      rsw_pkg::DLY_20K:
      begin
        por_term  = 32'(POR_CYC * 2);
        boot_term = 32'(BOOT_CYC * 2);
        kick_term = 32'(KICK_CYC * 2);
      end
      rsw_pkg::DLY_30K:
      begin
        por_term  = 32'(POR_CYC * 3);
        boot_term = 32'(BOOT_CYC * 3);
        kick_term = 32'(KICK_CYC * 3);
      end
      default:
      begin
        por_term  = POR_OPEN_CYC;
        boot_term = BOOT_OPEN_CYC;
        kick_term = KICK_OPEN_CYC;
      end
    endcase
  end

  assign wd_timeout = (wd_r == rsw_pkg::WD_MON) && !kick_fall &&
                      (wd_cnt_r >= kick_term - 32'h1);

  // Main power sequencer
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      st_r    <= rsw_pkg::ST_OFF;
      latch_r <= 1'b0;
    end
    else if (sup_fail)
    begin
      st_r    <= rsw_pkg::ST_OFF;
      latch_r <= 1'b0;
    end
    else if (hot_or_over)
      st_r <= rsw_pkg::ST_SHUT;
    else
    begin
      case (st_r)
        rsw_pkg::ST_OFF:
          st_r <= rsw_pkg::ST_STANDBY;
        rsw_pkg::ST_STANDBY:
          if (en_s)
            st_r <= rsw_pkg::ST_LDO_UP;
        rsw_pkg::ST_SHUT:
          st_r <= rsw_pkg::ST_LDO_UP;
        rsw_pkg::ST_LDO_UP:
          if (ldo_ok)
          begin
            st_r    <= rsw_pkg::ST_SOFT;
            latch_r <= 1'b1;
          end
          else if (!en_s && !latch_r)
            st_r <= rsw_pkg::ST_STANDBY;
        rsw_pkg::ST_SOFT:
          if (ss_done_r)
            st_r <= rsw_pkg::ST_RUN;
        rsw_pkg::ST_RUN:
          if (pin_r[`RSW_IN_FB_SHORT])
          begin
            latch_r <= 1'b0;
            st_r    <= en_s ? rsw_pkg::ST_LATCHOFF : rsw_pkg::ST_STANDBY;
          end
          else if (!en_s && (!reg_ok || wd_timeout))
          begin
            latch_r <= 1'b0;
            st_r    <= rsw_pkg::ST_STANDBY;
          end
        rsw_pkg::ST_LATCHOFF:
          if (en_s && short_en_seen_low_r)
          begin
            latch_r <= 1'b1;
            st_r    <= rsw_pkg::ST_SOFT;
          end
        default:
          st_r <= rsw_pkg::ST_OFF;
      endcase
    end
  end

  // Short restart needs enable low then high
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
      short_en_seen_low_r <= 1'b0;
    else if (st_r != rsw_pkg::ST_LATCHOFF)
      short_en_seen_low_r <= 1'b0;
    else if (!en_s)
      short_en_seen_low_r <= 1'b1;
  end

  // Soft-start timer; restarted by every entry to soft-start, from LDO bring-up or latch-off
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      ss_cnt_r  <= '0;
      ss_done_r <= 1'b0;
    end
    else if (st_r != rsw_pkg::ST_SOFT && st_r != rsw_pkg::ST_RUN)
    begin
      ss_cnt_r  <= '0;
      ss_done_r <= 1'b0;
    end
    else if (!ss_done_r)
    begin
      ss_cnt_r  <= ss_cnt_r + 32'h1;
      ss_done_r <= (ss_cnt_r >= SS_CYC - 32'h1);
    end
  end

  // Watchdog: power-on hold, boot window, then kick monitoring
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      wd_r     <= rsw_pkg::WD_IDLE;
      wd_cnt_r <= '0;
    end
    else if ((st_r != rsw_pkg::ST_SOFT && st_r != rsw_pkg::ST_RUN) || !reg_ok)
    begin
      wd_r     <= rsw_pkg::WD_IDLE;
      wd_cnt_r <= '0;
    end
    else
    begin
      case (wd_r)
        rsw_pkg::WD_IDLE:
          if (pin_r[`RSW_IN_FB_HIGH])
          begin
            wd_r     <= rsw_pkg::WD_POR;
            wd_cnt_r <= '0;
          end
        rsw_pkg::WD_POR:
          if (wd_cnt_r >= por_term - 32'h1)
          begin
            wd_r     <= rsw_pkg::WD_BOOT;
            wd_cnt_r <= '0;
          end
          else
            wd_cnt_r <= wd_cnt_r + 32'h1;
        rsw_pkg::WD_BOOT:
          if (wd_cnt_r >= boot_term - 32'h1)
          begin
            wd_r     <= rsw_pkg::WD_MON;
            wd_cnt_r <= '0;
          end
          else
            wd_cnt_r <= wd_cnt_r + 32'h1;
        rsw_pkg::WD_MON:
          if (kick_fall)
            wd_cnt_r <= '0;
          else if (wd_timeout)
          begin
            wd_r     <= rsw_pkg::WD_POR;
            wd_cnt_r <= '0;
          end
          else
            wd_cnt_r <= wd_cnt_r + 32'h1;
        default:
          wd_r <= rsw_pkg::WD_IDLE;
      endcase
    end
  end

  // Ignition mirror follows enable only while latched, otherwise holds
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
      ign_r <= 1'b0;
    else if (latch_r)
      ign_r <= en_s;
  end

  // Outputs decoded from state, power good from the five-volt low pin; LDO current limit lives in the analog loop
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      system_reset_out_n    <= 1'b0;
      five_volt_ldo_en_out  <= 1'b0;
      gate_drive_ldo_en_out <= 1'b0;
      smps_switch_en_out    <= 1'b0;
      soft_start_run_out    <= 1'b0;
      ldo_power_good_out    <= 1'b0;
      ignition_mirror_out   <= 1'b0;
    end
    else
    begin
      system_reset_out_n    <= (wd_r == rsw_pkg::WD_BOOT) || (wd_r == rsw_pkg::WD_MON);
      five_volt_ldo_en_out  <= (st_r == rsw_pkg::ST_LDO_UP) || (st_r == rsw_pkg::ST_SOFT) ||
                               (st_r == rsw_pkg::ST_RUN) || (st_r == rsw_pkg::ST_LATCHOFF);
      gate_drive_ldo_en_out <= (st_r == rsw_pkg::ST_LDO_UP) || (st_r == rsw_pkg::ST_SOFT) ||
                               (st_r == rsw_pkg::ST_RUN) || (st_r == rsw_pkg::ST_LATCHOFF);
      smps_switch_en_out    <= (st_r == rsw_pkg::ST_SOFT) || (st_r == rsw_pkg::ST_RUN);
      soft_start_run_out    <= (st_r == rsw_pkg::ST_SOFT) || (st_r == rsw_pkg::ST_RUN);
      ldo_power_good_out    <= ~pin_r[`RSW_IN_FIVE_LOW];
      ignition_mirror_out   <= ign_r;
    end
  end

  // Wishbone classic slave: one wait state, ack drops the cycle after
  assign wb_hit = wb_req_in.cyc && wb_req_in.stb && !ack_r;
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      ack_r     <= 1'b0;
      rdat_r    <= '0;
      dly_sel_r <= rsw_pkg::rsw_dly_t'(`RSW_CTRL_RST);
    end
    else
    begin
      ack_r <= wb_hit;
      if (wb_hit && wb_req_in.we && wb_req_in.sel[0] && wb_req_in.adr == `RSW_ADR_CTRL)
        dly_sel_r <= rsw_pkg::rsw_dly_t'(wb_req_in.dat[1:0]);
      if (wb_hit && !wb_req_in.we)
      begin
        case (wb_req_in.adr)
          `RSW_ADR_CTRL:   rdat_r <= {30'h0, dly_sel_r};
          `RSW_ADR_STATUS: rdat_r <= {18'h0, wd_r, latch_r, ss_done_r, st_r, system_reset_out_n};
          default:         rdat_r <= 32'h0;
        endcase
      end
    end
  end
  // One driver for the whole response word
  assign wb_rsp_out = '{ack: ack_r, dat: rdat_r};

endmodule : rsw_top
